/* src/ccp_channel.sv */
// Capture/compare channel with reference timer and AXI4-Lite registers
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "ccp_consts.svh"
module ccp_channel
  import ccp_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic        SLEEP,
  input  wire logic        EXT_TICK,
  input  wire logic        ADC_ENABLED,
  input  wire logic        CHANNEL_PIN_IN,
  output logic             CHANNEL_PIN_OUT,
  output logic             CHANNEL_PIN_OE,
  output logic             ADC_START,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP
);
  logic [7:0]  control_q;
  logic [15:0] match_q;
  logic [15:0] count_q;
  logic        tmr_on_q;
  logic        tmr_ext_q;
  logic        ovf_flag_q;
  logic        event_flag_q;
  logic        pin_q;
  logic        latch_q;
  logic [4:0]  pscl_q;
  logic        trig_pend_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        aw_have_q;
  logic        w_have_q;

  mode_e       mode;
  logic        tick;
  logic        match;
  logic        is_cap;
  logic        is_cmp;
  logic        rise;
  logic        fall;
  logic        cap_edge;
  logic        cap_event;
  logic        cmp_event;
  logic        do_write;
  logic        wr_ctrl;
  logic        wr_mlo;
  logic        wr_mhi;
  logic        wr_stat;
  logic        wr_tlo;
  logic        wr_thi;
  logic        wr_tctl;
  logic [4:0]  pscl_target;

  assign mode = mode_e'(control_q[`MODE_MSB:`MODE_LSB]);
  // R11: instruction-clock timer frozen in sleep; R12: external tick keeps counting
  assign tick = tmr_on_q && (tmr_ext_q ? EXT_TICK : !SLEEP);
  // R13: continuous 16-bit compare
  assign match = (count_q == match_q);
  assign is_cap = (mode == MODE_CAP_FALL) || (mode == MODE_CAP_RISE) ||
                  (mode == MODE_CAP_RISE4) || (mode == MODE_CAP_RISE16);
  assign is_cmp = (mode == MODE_CMP_TOG) || (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLR) ||
                  (mode == MODE_CMP_IRQ) || (mode == MODE_CMP_TRIG);
  // R5: edges seen on the pin level itself, even when we drive it
  assign rise = CHANNEL_PIN_IN && !pin_q;
  assign fall = !CHANNEL_PIN_IN && pin_q;
  assign cap_edge = (mode == MODE_CAP_FALL) ? fall : rise;

  // R2: prescale targets; R24: distinct codes
  always_comb begin
    case (mode)
      MODE_CAP_RISE4:  pscl_target = `PRESCALE_4;
      MODE_CAP_RISE16: pscl_target = `PRESCALE_16;
      default:         pscl_target = 5'h01;
    endcase
  end
  assign cap_event = is_cap && cap_edge && (5'(pscl_q + 5'h01) >= pscl_target);
  // Edge-triggered so a stalled timer does not flag every cycle
  assign cmp_event = is_cmp && match && (tick || trig_pend_q == 1'b0) && !latch_q;

  assign do_write = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign wr_ctrl = do_write && (awaddr_q == `OFS_CONTROL) && (wdata_q[30] == 1'b0);
  assign wr_mlo  = do_write && (awaddr_q == `OFS_MATCH_LOW);
  assign wr_mhi  = do_write && (awaddr_q == `OFS_MATCH_HIGH);
  assign wr_stat = do_write && (awaddr_q == `OFS_STATUS);
  assign wr_tlo  = do_write && (awaddr_q == `OFS_TIMER_LOW);
  assign wr_thi  = do_write && (awaddr_q == `OFS_TIMER_HIGH);
  assign wr_tctl = do_write && (awaddr_q == `OFS_TIMER_CTRL);

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= CHANNEL_PIN_IN;
    end
  end

  // Match seen once per match episode
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= is_cmp && match;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pscl_q <= 5'h00;
    end else if (!is_cap) begin
      // R9: cleared when off or not capturing
      pscl_q <= 5'h00;
    end else if (cap_edge) begin
      // R10: prescale switch keeps count, so may fire early
      pscl_q <= cap_event ? 5'h00 : 5'(pscl_q + 5'h01);
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      control_q <= `CONTROL_RESET;
    end else if (wr_ctrl) begin
      control_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      match_q <= 16'h0000;
    end else if (cap_event) begin
      // R1: capture timer into pair; R3: overwrite unread value
      match_q <= count_q;
    end else if (wr_mlo) begin
      match_q[7:0] <= wdata_q[7:0];
    end else if (wr_mhi) begin
      match_q[15:8] <= wdata_q[7:0];
    end
  end

  // R20: trigger armed on match, timer zeroed on next tick
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      trig_pend_q <= 1'b0;
    end else if (mode != MODE_CMP_TRIG) begin
      trig_pend_q <= 1'b0;
    end else if (tick) begin
      trig_pend_q <= 1'b0;
    end else if (cmp_event) begin
      trig_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      count_q    <= 16'h0000;
      ovf_flag_q <= 1'b0;
    end else begin
      if (wr_tlo) begin
        count_q[7:0] <= wdata_q[7:0];
      end else if (wr_thi) begin
        count_q[15:8] <= wdata_q[7:0];
      end else if (tick) begin
        // R19: trigger resets timer; R22: only while match still holds
        if (mode == MODE_CMP_TRIG && match && (trig_pend_q || cmp_event)) begin
          // R21: no overflow flag from trigger reset
          count_q <= 16'h0000;
        end else begin
          count_q <= 16'(count_q + 16'h0001);
          if (count_q == 16'hFFFF) begin
            ovf_flag_q <= 1'b1;
          end
        end
      end
      if (wr_stat && wdata_q[1] && !(tick && count_q == 16'hFFFF)) begin
        ovf_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tmr_on_q  <= 1'b0;
      tmr_ext_q <= 1'b0;
    end else if (wr_tctl) begin
      tmr_on_q  <= wdata_q[0];
      tmr_ext_q <= wdata_q[1];
    end
  end

  // R3: set wins over software clear; R7: mode change may leave a flag
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      event_flag_q <= 1'b0;
    end else if (cap_event || cmp_event) begin
      // R14: flag in every compare mode
      event_flag_q <= 1'b1;
    end else if (wr_stat && wdata_q[0]) begin
      event_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      CHANNEL_PIN_OUT <= 1'b0;
      CHANNEL_PIN_OE  <= 1'b0;
      ADC_START       <= 1'b0;
    end else begin
      // R23: compare runs only on the core clock
      CHANNEL_PIN_OE <= (mode == MODE_CMP_TOG) || (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLR);
      // R19: conversion pulse on match if converter enabled
      ADC_START <= cmp_event && (mode == MODE_CMP_TRIG) && ADC_ENABLED;
      if (wr_ctrl && wdata_q[7:0] == 8'h00) begin
        // R16: control write of zero drops latch low
        CHANNEL_PIN_OUT <= 1'b0;
      end else if (cmp_event) begin
        // R14: pin action; R18: interrupt-only leaves pin alone
        case (mode)
          MODE_CMP_TOG: CHANNEL_PIN_OUT <= !CHANNEL_PIN_OUT;
          MODE_CMP_SET: CHANNEL_PIN_OUT <= 1'b1;
          MODE_CMP_CLR: CHANNEL_PIN_OUT <= 1'b0;
          default:      CHANNEL_PIN_OUT <= CHANNEL_PIN_OUT;
        endcase
      end
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY && S_AXI_AWVALID && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_have_q && !S_AXI_WREADY && S_AXI_WVALID && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {S_AXI_AWADDR[11:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q  <= {1'b0, !S_AXI_WSTRB[0], S_AXI_WDATA[29:0]};
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (awaddr_q <= `OFS_TIMER_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && S_AXI_ARVALID && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `RESP_OKAY;
        case ({S_AXI_ARADDR[11:2], 2'b00})
          `OFS_CONTROL:    S_AXI_RDATA <= {24'h000000, control_q};
          `OFS_MATCH_LOW:  S_AXI_RDATA <= {24'h000000, match_q[7:0]};
          `OFS_MATCH_HIGH: S_AXI_RDATA <= {24'h000000, match_q[15:8]};
          `OFS_STATUS:     S_AXI_RDATA <= {30'h0, ovf_flag_q, event_flag_q};
          `OFS_TIMER_LOW:  S_AXI_RDATA <= {24'h000000, count_q[7:0]};
          `OFS_TIMER_HIGH: S_AXI_RDATA <= {24'h000000, count_q[15:8]};
          `OFS_TIMER_CTRL: S_AXI_RDATA <= {30'h0, tmr_ext_q, tmr_on_q};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

/* include/ccp_consts.svh */
// Constants for the capture/compare channel
// Behaviour
// R1: Capture copies 16-bit timer into pair
// R2: Capture on fall, rise, 4th, 16th rise
// R3: Capture sets flag; overwrite unread value
// R4: Software makes pin input for capture
// R5: Edge detector watches pin itself
// R6: Timer must be synchronous for capture
// R7: Mode change may set spurious flag
// R8: Timer clocked from instruction clock
// R9: Prescaler cleared off, non-capture, reset
// R10: Prescale switch keeps counter, may falsely flag
// R11: Timer holds count during sleep
// R12: Capture works in sleep with external clock
// R13: Compare pair matched against timer continuously
// R14: Match does mode action, sets flag
// R15: Software makes pin output for compare
// R16: Control zero forces compare latch low
// R17: Timer must be synchronous for compare
// R18: Mode 1010 flags only, pin free
// R19: Mode 1011 resets timer, starts conversion
// R20: Trigger immediate, timer zeroed next tick
// R21: Trigger reset leaves overflow flag alone
// R22: Lost match cancels pending timer reset
// R23: Compare not guaranteed in sleep
// R24: Distinct codes for each capture/compare mode
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
`define OFS_CONTROL     12'h000
`define OFS_MATCH_LOW   12'h004
`define OFS_MATCH_HIGH  12'h008
`define OFS_STATUS      12'h00C
`define OFS_TIMER_LOW   12'h010
`define OFS_TIMER_HIGH  12'h014
`define OFS_TIMER_CTRL  12'h018
`define MODE_LSB        0
`define MODE_MSB        3
`define CONTROL_RESET   8'h00
`define PRESCALE_4      5'h04
`define PRESCALE_16     5'h10
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

/* include/ccp_pkg.sv */
// Types for the capture/compare channel
package ccp_pkg;
  typedef enum logic [3:0] {
    MODE_OFF       = 4'b0000,
    MODE_CMP_TOG   = 4'b0010,
    MODE_CAP_FALL  = 4'b0100,
    MODE_CAP_RISE  = 4'b0101,
    MODE_CAP_RISE4 = 4'b0110,
    MODE_CAP_RISE16= 4'b0111,
    MODE_CMP_SET   = 4'b1000,
    MODE_CMP_CLR   = 4'b1001,
    MODE_CMP_IRQ   = 4'b1010,
    MODE_CMP_TRIG  = 4'b1011
  } mode_e;
endpackage

/* tb/ccp_checker.sv */
// Assertion checker for the capture/compare channel ports
`timescale 1ns/1ns
module ccp_checker
  import ccp_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        ADC_ENABLED,
  input wire logic        CHANNEL_PIN_OUT,
  input wire logic        CHANNEL_PIN_OE,
  input wire logic        ADC_START,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP
);
  logic [11:0] wa_q;
  logic [3:0]  wd_q;
  logic [3:0]  md_q;
  logic        bv_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // Mode copy lags the design by one cycle; checks allow for it
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wa_q <= '0;
      wd_q <= '0;
      md_q <= '0;
      bv_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) wa_q <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) wd_q <= S_AXI_WDATA[3:0];
      bv_q <= S_AXI_BVALID;
      if (S_AXI_BVALID && !bv_q && wa_q == 12'h000) md_q <= wd_q;
    end
  end
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read response dropped or changed");
  AST_AR_REFUSE: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while response pending");
  AST_UNMAPPED: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 12'h01B
    |=> S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  AST_OE_MODE: assert property ($rose(CHANNEL_PIN_OE) |=> md_q inside {MODE_CMP_TOG, MODE_CMP_SET, MODE_CMP_CLR})
    else $error("pin driven outside pin compare modes");
  AST_SET_HOLD: assert property ($fell(CHANNEL_PIN_OUT) |=> md_q != MODE_CMP_SET)
    else $error("pin fell in set mode");
  AST_CLR_HOLD: assert property ($rose(CHANNEL_PIN_OUT) |=> md_q != MODE_CMP_CLR)
    else $error("pin rose in clear mode");
  AST_LOW_OFF: assert property ($changed(md_q) && md_q == MODE_OFF |-> !CHANNEL_PIN_OUT)
    else $error("output latch not low after control cleared");
  AST_ADC_CAUSE: assert property (ADC_START |-> $past(ADC_ENABLED) && md_q == MODE_CMP_TRIG)
    else $error("conversion start without trigger mode");
  AST_ADC_PULSE: assert property (ADC_START |=> !ADC_START)
    else $error("conversion start longer than one cycle");
  cover property (ADC_START);
  cover property ($rose(CHANNEL_PIN_OE));
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule
bind ccp_channel ccp_checker chk(.*);

/* tb/ccp_pin_model.sv */
// Pin and tick source model for the channel's far side
`timescale 1ns/1ns
module ccp_pin_model(
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_in,
  output logic      ext_tick
);
  logic lvl_q = 1'b0;
  initial ext_tick = 1'b0;
  // pad shows own drive, else source
  assign pin_in = pin_oe ? pin_out : lvl_q;
  // Gap widens the pulse for a slow source
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      lvl_q <= 1'b1;
      repeat (2 + gap) @(posedge clk);
      lvl_q <= 1'b0;
      repeat (2 + gap) @(posedge clk);
    end
  endtask
  task automatic ticks(input int n);
    @(posedge clk);
    ext_tick <= 1'b1;
    repeat (n) @(posedge clk);
    ext_tick <= 1'b0;
  endtask
endmodule

/* tb/ccp_channel_tb.sv */
// Self-checking bench for the capture/compare channel
`timescale 1ns/1ns
module ccp_channel_tb;
  import ccp_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_s;
  logic        clk = 0, nrst = 0, sleep = 0, adc_en = 0;
  logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic [15:0] v;
  wire         pin_in, pin_out, pin_oe, adc_start, ext_tick, awr, wrdy, bv, arr, rv;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          failures = 0, cmp_count = 0, i;
  exp_s        q[$], e;
  logic [3:0]  cap_m[4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
  int          cap_n[4] = '{1, 1, 4, 16};
  logic [3:0]  cmp_m[4] = '{MODE_CMP_TOG, MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_IRQ};
  logic        cmp_o[4] = '{1, 1, 0, 0};
  logic        cmp_e[4] = '{1, 1, 1, 0};
  always #25 clk = ~clk;
  ccp_channel dut(.CORE_CLK(clk), .NRST(nrst), .SLEEP(sleep), .EXT_TICK(ext_tick),
    .ADC_ENABLED(adc_en), .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out),
    .CHANNEL_PIN_OE(pin_oe), .ADC_START(adc_start), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));
  ccp_pin_model pm(.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_tick(ext_tick));
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task timeout;
    failures++;
    $display("unexpected at %0t: wait ran out", $time);
    end_sim();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    @(posedge clk);
    awv <= 1; wv <= 1; awa <= a; wd <= d; bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr && awv) awv <= 0;
      if (wrdy && wv) wv <= 0;
      if (bv) break;
    end
    bready <= 0;
    if (n == 40) timeout();
    check(bresp, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, m = '1, input logic [1:0] r = 2'h0);
    int n;
    q.push_back('{d, m, r});
    @(posedge clk);
    arv <= 1; ara <= a; rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr && arv) arv <= 0;
      if (rv) break;
    end
    rready <= 0;
    if (n == 40) timeout();
  endtask
  // Oldest note pairs with each read answer
  always @(posedge clk) if (rv && rready) begin
    e = q.pop_front();
    check(rdata & e.m, e.d);
    check(rresp, e.r);
  end
  initial begin
    repeat (2000) @(posedge clk);
    timeout();
  end
  initial begin
    void'($urandom(29));
    repeat (6) @(posedge clk);
    nrst <= 1;
    rd(12'h000, 0);
    rd(12'h100, 0, '1, 2'h2);
    wr(12'h100, 0, 2'h2);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr(12'h000, 0);
      // timer stopped so the capture returns the loaded value
      wr(12'h018, 0);
      wr(12'h010, v[7:0]);
      wr(12'h014, v[15:8]);
      wr(12'h000, cap_m[i]);
      wr(12'h00C, 1);
      pm.pulses(cap_n[i] - 1, i);
      rd(12'h00C, 0, 1);
      pm.pulses(1, 0);
      rd(12'h00C, 1, 1);
      rd(12'h004, v[7:0]);
      rd(12'h008, v[15:8]);
    end
    $display("test capture done");
    for (i = 0; i < 4; i++) begin
      wr(12'h000, 0);
      wr(12'h018, 0);
      wr(12'h010, 0);
      wr(12'h014, 0);
      wr(12'h004, 8'h40);
      wr(12'h008, 0);
      wr(12'h00C, 1);
      wr(12'h000, cmp_m[i]);
      wr(12'h018, 1);
      repeat (100) @(posedge clk);
      rd(12'h00C, 1, 1);
      check(pin_out, cmp_o[i]);
      check(pin_oe, cmp_e[i]);
      wr(12'h000, 0);
      repeat (2) @(posedge clk);
      check(pin_out, 0);
    end
    $display("test compare done");
    adc_en <= 1;
    wr(12'h018, 0);
    wr(12'h010, 0);
    wr(12'h00C, 3);
    wr(12'h000, MODE_CMP_TRIG);
    wr(12'h018, 1);
    for (i = 0; i < 200 && adc_start !== 1'b1; i++) @(posedge clk);
    if (i == 200) timeout();
    rd(12'h010, 0, 32'hC0);
    rd(12'h00C, 1, 3);
    check(pin_oe, 0);
    adc_en <= 0;
    $display("test trigger done");
    wr(12'h000, 0);
    sleep <= 1;
    wr(12'h010, 8'h5A);
    wr(12'h014, 0);
    repeat (20) @(posedge clk);
    rd(12'h010, 8'h5A);
    wr(12'h018, 3);
    wr(12'h010, 0);
    pm.ticks(5);
    rd(12'h010, 5);
    wr(12'h000, MODE_CAP_RISE);
    pm.pulses(1, 0);
    rd(12'h004, 5);
    wr(12'h000, 0);
    sleep <= 0;
    $display("test sleep done");
    end_sim();
  end
endmodule
